// >>> hdl/control_and_indirect_op_decode.sv
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - PC change costs two cycles, except software reset
// - Window access with address MSB adds cycle
// - Relative jumps decoded, two cycles each
// - Invoke, invoke by accum, absolute jump: two
// - Exit with literal loads accum, pops, two
// - Plain and interrupt exits pop, two cycles
// - Watchdog kick clears timer, sets flags
// - Timer config load copies accum, one cycle
// - Software reset, one cycle
// - Standby entry, one cycle, updates flags
// - Direction load copies accum to selected register
// - Pointer add literal, one cycle, flags kept
// - Modified load via pointer, zero flag
// - Indexed load via pointer, zero flag
// - Modified store via pointer, flags kept
// - Indexed store via pointer, flags kept
// - Sign-extended six-bit literal added to pair
// - Pointer wraps modulo sixteen bits
// - AND literal into accum, zero flag only
// - Add literal, carry, digit carry, zero
// - AND file, destination bit picks target
module control_and_indirect_op_decode import decode_pkg::*; (
  input wire logic ref_clk, // core clock
  input wire logic rst_b, // async reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic busy, // instruction in flight
  output logic wdt_clear, // watchdog clear pulse
  output logic standby_req, // standby entry pulse
  output logic soft_reset_req // software reset pulse
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  exec_state_t state_q;
  logic [13:0] ir_q;
  logic [7:0] acc_q;
  logic [4:0] stat_q;
  logic [PC_W-1:0] pc_q;
  logic [15:0] ptr_q [2];
  logic [7:0] opt_q;
  logic [7:0] dir_q [NDIR];
  logic [7:0] mem_q [NMEM];
  logic [PC_W-1:0] stk_q [NSTK];
  logic [1:0] sp_q;
  logic [1:0] cyc_q;
  logic [1:0] left_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic hit(input logic [13:0] op,
                               input logic [13:0] m,
                               input logic [13:0] v);
    hit = (op & m) == v;
  endfunction

  // ------------------------------------------------------------------
  // Decode and execute, one instruction cycle per clock
  // ------------------------------------------------------------------
  logic acc_we, z_we, cdc_we, mem_we, ptr_we, dir_we, opt_we;
  logic push, pop, kick, sleep, srst, win;
  logic n;
  logic [7:0] acc_d, res, opnd, mem_val;
  logic [2:0] mem_idx;
  logic [15:0] ptr_d, ea, step;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [PC_W-1:0] pc_d, pc1;
  logic [1:0] cyc_d;

  always_comb begin
    acc_we = 1'b0;
    z_we = 1'b0;
    cdc_we = 1'b0;
    mem_we = 1'b0;
    ptr_we = 1'b0;
    dir_we = 1'b0;
    opt_we = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    kick = 1'b0;
    sleep = 1'b0;
    srst = 1'b0;
    win = 1'b0;
    n = ir_q[6];
    acc_d = acc_q;
    res = acc_q;
    mem_val = acc_q;
    ptr_d = ptr_q[ir_q[6]];
    step = ir_q[0] ? 16'hFFFF : 16'h0001;
    ea = ptr_q[ir_q[6]];
    mem_idx = ir_q[2:0];
    sum = {1'b0, acc_q} + {1'b0, ir_q[7:0]};
    nib = {1'b0, acc_q[3:0]} + {1'b0, ir_q[3:0]};
    pc1 = pc_q + 15'h0001;
    pc_d = pc1;
    cyc_d = CYC_ONE;
    opnd = mem_q[ir_q[2:0]];
    if (hit(ir_q, M_REL, OP_REL_LIT)) begin
      pc_d = pc1 + {{6{ir_q[8]}}, ir_q[8:0]};
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_ALL, OP_REL_ACC)) begin
      pc_d = pc1 + {7'h00, acc_q};
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_JUMP, OP_INVOKE)) begin
      push = 1'b1;
      pc_d = {pc_q[PC_W-1:11], ir_q[10:0]};
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_ALL, OP_INVOKE_ACC)) begin
      push = 1'b1;
      pc_d = {pc_q[PC_W-1:8], acc_q};
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_JUMP, OP_ABS_JUMP)) begin
      pc_d = {pc_q[PC_W-1:11], ir_q[10:0]};
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_BYTE, OP_EXIT_LIT)) begin
      pop = 1'b1;
      acc_we = 1'b1;
      acc_d = ir_q[7:0];
      pc_d = stk_q[sp_q - 2'h1];
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_ALL, OP_SUB_EXIT) ||
                 hit(ir_q, M_ALL, OP_INT_EXIT)) begin
      pop = 1'b1;
      pc_d = stk_q[sp_q - 2'h1];
      cyc_d = CYC_TWO;
    end else if (hit(ir_q, M_ALL, OP_KICK)) begin
      kick = 1'b1;
    end else if (hit(ir_q, M_ALL, OP_OPTION)) begin
      opt_we = 1'b1;
    end else if (hit(ir_q, M_ALL, OP_SW_RESET)) begin
      srst = 1'b1;
      pc_d = '0;
    end else if (hit(ir_q, M_ALL, OP_STANDBY)) begin
      sleep = 1'b1;
    end else if (hit(ir_q, M_MOD, OP_DIR_LOAD)) begin
      dir_we = 1'b1;
    end else if (hit(ir_q, M_PTR, OP_PTR_ADD)) begin
      ptr_we = 1'b1;
      ptr_d = ptr_q[n] + {{10{ir_q[5]}}, ir_q[5:0]};
    end else if (hit(ir_q, M_MOD, OP_LOAD_MOD) ||
                 hit(ir_q, M_MOD, OP_STORE_MOD)) begin
      n = ir_q[2];
      ptr_we = 1'b1;
      ptr_d = ptr_q[n] + step;
      ea = ir_q[1] ? ptr_q[n] : ptr_d;
      mem_idx = ea[2:0];
      win = 1'b1;
      if (ir_q[3]) begin
        mem_we = 1'b1;
      end else begin
        acc_we = 1'b1;
        acc_d = mem_q[mem_idx];
        z_we = 1'b1;
      end
    end else if (hit(ir_q, M_PTR, OP_LOAD_IDX) ||
                 hit(ir_q, M_PTR, OP_STORE_IDX)) begin
      ea = ptr_q[n] + {{10{ir_q[5]}}, ir_q[5:0]};
      mem_idx = ea[2:0];
      win = 1'b1;
      if (ir_q[7]) begin
        mem_we = 1'b1;
      end else begin
        acc_we = 1'b1;
        acc_d = mem_q[mem_idx];
        z_we = 1'b1;
      end
    end else if (hit(ir_q, M_BYTE, OP_AND_LIT)) begin
      acc_we = 1'b1;
      acc_d = acc_q & ir_q[7:0];
      z_we = 1'b1;
    end else if (hit(ir_q, M_BYTE, OP_ADD_LIT)) begin
      acc_we = 1'b1;
      acc_d = sum[7:0];
      z_we = 1'b1;
      cdc_we = 1'b1;
    end else if (hit(ir_q, M_BYTE, OP_AND_FILE)) begin
      if (ir_q[6:0] == WIN0 || ir_q[6:0] == WIN1) begin
        n = ir_q[0];
        ea = ptr_q[n];
        mem_idx = ea[2:0];
        win = 1'b1;
      end
      opnd = mem_q[mem_idx];
      res = acc_q & opnd;
      mem_val = res;
      z_we = 1'b1;
      if (ir_q[7]) begin
        mem_we = 1'b1;
      end else begin
        acc_we = 1'b1;
        acc_d = res;
      end
    end
    if (win && ea[15]) begin
      cyc_d = cyc_d + CYC_ONE;
    end
  end

  // ------------------------------------------------------------------
  // Sequencing: first cycle executes, the rest run as no-operations
  // ------------------------------------------------------------------
  logic wr_fire, rd_fire, start;
  assign start = wr_fire && awaddr_q == A_INSTR && state_q == S_IDLE;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      left_q <= '0;
      cyc_q <= '0;
      ir_q <= '0;
      busy <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start) begin
            ir_q <= wdata_q[13:0];
            state_q <= S_EXEC;
            busy <= 1'b1;
          end
        end
        S_EXEC: begin
          cyc_q <= cyc_d;
          left_q <= cyc_d - CYC_ONE;
          if (cyc_d == CYC_ONE) begin
            state_q <= S_IDLE;
            busy <= 1'b0;
          end else begin
            state_q <= S_STALL;
          end
        end
        S_STALL: begin
          left_q <= left_q - CYC_ONE;
          if (left_q == CYC_ONE) begin
            state_q <= S_IDLE;
            busy <= 1'b0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  logic exec;
  assign exec = state_q == S_EXEC;

  // ------------------------------------------------------------------
  // Architectural registers
  // ------------------------------------------------------------------
  logic sw_we;
  assign sw_we = wr_fire && state_q == S_IDLE;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= '0;
      stat_q <= STATUS_RST;
      pc_q <= '0;
      opt_q <= OPTION_RST;
      sp_q <= '0;
      wdt_clear <= 1'b0;
      standby_req <= 1'b0;
      soft_reset_req <= 1'b0;
    end else begin
      wdt_clear <= exec && kick;
      standby_req <= exec && sleep;
      soft_reset_req <= exec && srst;
      if (exec) begin
        pc_q <= pc_d;
        if (acc_we) acc_q <= acc_d;
        if (opt_we) opt_q <= acc_q;
        if (z_we) stat_q[ST_Z] <= acc_we ? acc_d == 8'h00 : res == 8'h00;
        if (cdc_we) begin
          stat_q[ST_C] <= sum[8];
          stat_q[ST_DC] <= nib[4];
        end
        if (kick) begin
          stat_q[ST_WDT_EXPIRED] <= 1'b1;
          stat_q[ST_PWR_DOWN] <= 1'b1;
        end
        if (sleep) begin
          stat_q[ST_WDT_EXPIRED] <= 1'b1;
          stat_q[ST_PWR_DOWN] <= 1'b0;
        end
        if (push) sp_q <= sp_q + 2'h1;
        if (pop) sp_q <= sp_q - 2'h1;
      end else if (sw_we && awaddr_q == A_ACCUM && wstrb_q[0]) begin
        acc_q <= wdata_q[7:0];
      end
    end
  end

  // Pointers: writable by software while idle, stepped by execution.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q[0] <= '0;
      ptr_q[1] <= '0;
    end else if (exec && ptr_we) begin
      ptr_q[n] <= ptr_d;
    end else if (sw_we && (awaddr_q == A_PTR0 || awaddr_q == A_PTR1)) begin
      if (wstrb_q[0]) ptr_q[awaddr_q[2]][7:0] <= wdata_q[7:0];
      if (wstrb_q[1]) ptr_q[awaddr_q[2]][15:8] <= wdata_q[15:8];
    end
  end

  // Return stack, data bytes and direction registers, one per entry.
  genvar g;
  generate
    for (g = 0; g < NSTK; g++) begin : g_stk
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) stk_q[g] <= '0;
        else if (exec && push && sp_q == g) stk_q[g] <= pc1;
      end
    end
    for (g = 0; g < NMEM; g++) begin : g_mem
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_q[g] <= '0;
        end else if (exec && mem_we && mem_idx == g) begin
          mem_q[g] <= mem_val;
        end else if (sw_we && wstrb_q[0] &&
                     awaddr_q == A_MEM + 8'(4 * g)) begin
          mem_q[g] <= wdata_q[7:0];
        end
      end
    end
    for (g = 0; g < NDIR; g++) begin : g_dir
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) dir_q[g] <= DIR_RST;
        else if (exec && dir_we && ir_q[2:0] == g) dir_q[g] <= acc_q;
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // AXI4-Lite slave; address and data are taken in either order
  // ------------------------------------------------------------------
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  logic wr_ok;
  always_comb begin
    wr_ok = awaddr_q == A_INSTR || awaddr_q == A_ACCUM ||
            awaddr_q == A_PTR0 || awaddr_q == A_PTR1 ||
            (awaddr_q & A_TBL_MASK) == A_MEM;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ok && state_q == S_IDLE) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  logic [31:0] rd_d;
  logic rd_ok;
  always_comb begin
    rd_d = '0;
    rd_ok = 1'b1;
    if ((s_axi_araddr & A_TBL_MASK) == A_DIR) begin
      rd_d[7:0] = dir_q[s_axi_araddr[4:2]];
    end else if ((s_axi_araddr & A_TBL_MASK) == A_MEM) begin
      rd_d[7:0] = mem_q[s_axi_araddr[4:2]];
    end else begin
      case (s_axi_araddr)
        A_INSTR: rd_d = {busy, 17'h00000, ir_q};
        A_ACCUM: rd_d[7:0] = acc_q;
        A_STATUS: rd_d[4:0] = stat_q;
        A_PC: rd_d[PC_W-1:0] = pc_q;
        A_PTR0: rd_d[15:0] = ptr_q[0];
        A_PTR1: rd_d[15:0] = ptr_q[1];
        A_OPTION: rd_d[7:0] = opt_q;
        A_CYCLES: rd_d[1:0] = cyc_q;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// >>> hdl/decode_pkg.sv
package decode_pkg;
  // ------------------------------------------------------------------
  // Register map, one aligned word each
  // ------------------------------------------------------------------
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_ACCUM = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_PC = 8'h0C;
  localparam logic [7:0] A_PTR0 = 8'h10;
  localparam logic [7:0] A_PTR1 = 8'h14;
  localparam logic [7:0] A_OPTION = 8'h18;
  localparam logic [7:0] A_CYCLES = 8'h1C;
  localparam logic [7:0] A_DIR = 8'h20;
  localparam logic [7:0] A_MEM = 8'h40;
  localparam logic [7:0] A_TBL_MASK = 8'hE3;
  localparam int BUSY_BIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------------
  // Status bits and reset values
  // ------------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PWR_DOWN = 3;
  localparam int ST_WDT_EXPIRED = 4;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam int PC_W = 15;
  localparam int NDIR = 8;
  localparam int NMEM = 8;
  localparam int NSTK = 4;
  localparam logic [6:0] WIN0 = 7'h00;
  localparam logic [6:0] WIN1 = 7'h01;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // ------------------------------------------------------------------
  // Opcode masks and match values
  // ------------------------------------------------------------------
  localparam logic [13:0] M_ALL = 14'h3FFF;
  localparam logic [13:0] M_BYTE = 14'h3F00;
  localparam logic [13:0] M_JUMP = 14'h3800;
  localparam logic [13:0] M_REL = 14'h3E00;
  localparam logic [13:0] M_PTR = 14'h3F80;
  localparam logic [13:0] M_MOD = 14'h3FF8;
  localparam logic [13:0] OP_REL_LIT = 14'h3200;
  localparam logic [13:0] OP_REL_ACC = 14'h000B;
  localparam logic [13:0] OP_INVOKE = 14'h2000;
  localparam logic [13:0] OP_INVOKE_ACC = 14'h000A;
  localparam logic [13:0] OP_ABS_JUMP = 14'h2800;
  localparam logic [13:0] OP_SUB_EXIT = 14'h0008;
  localparam logic [13:0] OP_INT_EXIT = 14'h0009;
  localparam logic [13:0] OP_EXIT_LIT = 14'h3400;
  localparam logic [13:0] OP_KICK = 14'h0064;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [13:0] OP_SW_RESET = 14'h0001;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [13:0] OP_DIR_LOAD = 14'h0060;
  localparam logic [13:0] OP_PTR_ADD = 14'h3100;
  localparam logic [13:0] OP_LOAD_MOD = 14'h0010;
  localparam logic [13:0] OP_STORE_MOD = 14'h0018;
  localparam logic [13:0] OP_LOAD_IDX = 14'h3F00;
  localparam logic [13:0] OP_STORE_IDX = 14'h3F80;
  localparam logic [13:0] OP_AND_LIT = 14'h3900;
  localparam logic [13:0] OP_ADD_LIT = 14'h3E00;
  localparam logic [13:0] OP_AND_FILE = 14'h0500;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_STALL} exec_state_t;
endpackage

// >>> tb/control_and_indirect_op_decode_test.sv
`timescale 1ns/1ps
module control_and_indirect_op_decode_test import decode_pkg::*;;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat, sv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, busy, wdt_clear, standby_req, soft_reset_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, lr;
  logic [14:0] fpc = 15'h0;
  logic [13:0] word;
  int fail_count = 0, num_checks = 0, n_wdt = 0, n_stby = 0, n_rst = 0;
  localparam logic [14:0] PCS [8] = '{15'h0, 15'h8, 15'h4, 15'h7,
                                      15'h9, 15'hA, 15'hB, 15'hC};
  localparam int CYC [8] = '{2, 2, 2, 2, 1, 1, 1, 1};

  control_and_indirect_op_decode i_control_and_indirect_op_decode (
    .ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .busy, .wdt_clear, .standby_req,
    .soft_reset_req
  );
  prog_mem_model i_prog_mem_model (.ref_clk, .pc(fpc), .instr(word));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wdt_clear === 1'b1)
      n_wdt++;
    if (standby_req === 1'b1)
      n_stby++;
    if (soft_reset_req === 1'b1)
      n_rst++;
  end
  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task rsp(input logic [1:0] e);
    chk({30'h0, lr}, {30'h0, e});
  endtask
  // Each channel releases on its own handshake; bready stays up
  // from the start so the response is taken at the first chance.
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        lr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rdat = s_axi_rdata;
        lr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task ex(input logic [13:0] op, input int n);
    int c;
    wr(A_INSTR, {18'h0, op});
    rsp(RESP_OKAY);
    c = (busy === 1'b1) ? 1 : 0;
    while (busy === 1'b1 && c < 8) begin
      @(posedge ref_clk);
      if (busy === 1'b1)
        c++;
    end
    chk(c, n);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rc(A_STATUS, 32'h18);
    rc(A_OPTION, 32'hFF);
    rc(A_DIR + 8'h14, 32'hFF);
    rd(8'h60);
    rsp(RESP_SLVERR);
    wr(A_STATUS, 32'h0);
    rsp(RESP_SLVERR);
    rc(A_STATUS, 32'h18);
    $display("test regs done");
  endtask
  task t_prog;
    for (int i = 0; i < 8; i++) begin
      rd(A_PC);
      chk(rdat, {17'h0, PCS[i]});
      fpc <= rdat[14:0];
      repeat (2) @(posedge ref_clk);
      ex(word, CYC[i]);
    end
    rc(A_PC, 32'h0);
    rc(A_ACCUM, 32'h0);
    rc(A_STATUS, 32'h1F);
    chk(n_rst, 1);
    $display("test program done");
  endtask
  task t_ctl;
    wr(A_ACCUM, 32'h3);
    ex(OP_INVOKE | 14'h0020, 2);
    ex(OP_SUB_EXIT, 2);
    rc(A_PC, 32'h1);
    ex(OP_INVOKE_ACC, 2);
    rc(A_PC, 32'h3);
    ex(OP_INT_EXIT, 2);
    rc(A_PC, 32'h2);
    ex(OP_REL_ACC, 2);
    rc(A_PC, 32'h6);
    $display("test control done");
  endtask
  task t_inh;
    wr(A_ACCUM, 32'h3C);
    ex(OP_STANDBY, 1);
    rd(A_STATUS);
    chk(rdat & 32'h18, 32'h10);
    ex(OP_KICK, 1);
    rd(A_STATUS);
    chk(rdat & 32'h18, 32'h18);
    ex(OP_OPTION, 1);
    rc(A_OPTION, 32'h3C);
    ex(OP_DIR_LOAD | 14'h0005, 1);
    rc(A_DIR + 8'h14, 32'h3C);
    rc(A_DIR + 8'h18, 32'hFF);
    chk(n_stby, 1);
    chk(n_wdt, 2);
    $display("test inherent done");
  endtask
  task t_ptr;
    wr(A_PTR0, 32'h1);
    wr(A_PTR1, 32'hFFFF);
    rd(A_STATUS);
    sv = rdat;
    ex(OP_PTR_ADD | 14'h0020, 1);
    rc(A_PTR0, 32'hFFE1);
    ex(OP_PTR_ADD | 14'h001F, 1);
    rc(A_PTR0, 32'h0);
    ex(OP_PTR_ADD | 14'h0041, 1);
    rc(A_PTR1, 32'h0);
    rc(A_STATUS, sv);
    $display("test pointer done");
  endtask
  task t_ind;
    wr(A_PTR1, 32'h3);
    wr(A_ACCUM, 32'h77);
    rd(A_STATUS);
    sv = rdat;
    ex(OP_STORE_MOD | 14'h0006, 1);
    rc(A_MEM + 8'h0C, 32'h77);
    rc(A_PTR1, 32'h4);
    rc(A_STATUS, sv);
    wr(A_ACCUM, 32'h0);
    ex(OP_LOAD_MOD | 14'h0005, 1);
    rc(A_ACCUM, 32'h77);
    rc(A_PTR1, 32'h3);
    rd(A_STATUS);
    chk(rdat & 32'h4, 32'h0);
    ex(OP_STORE_MOD | 14'h0004, 1);
    rc(A_MEM + 8'h10, 32'h77);
    ex(OP_LOAD_MOD | 14'h0007, 1);
    rc(A_PTR1, 32'h3);
    wr(A_MEM + 8'h08, 32'h0);
    ex(OP_LOAD_IDX | 14'h007F, 1);
    rc(A_ACCUM, 32'h0);
    rd(A_STATUS);
    chk(rdat & 32'h4, 32'h4);
    wr(A_PTR0, 32'h8005);
    wr(A_ACCUM, 32'h42);
    rd(A_STATUS);
    sv = rdat;
    ex(OP_STORE_IDX | 14'h0001, 2);
    rc(A_MEM + 8'h18, 32'h42);
    rc(A_STATUS, sv);
    rc(A_CYCLES, 32'h2);
    ex(OP_LOAD_MOD | 14'h0003, 2);
    rc(A_PTR0, 32'h8004);
    $display("test indirect done");
  endtask
  task t_andf;
    wr(A_MEM + 8'h10, 32'h3C);
    wr(A_ACCUM, 32'h0F);
    ex(OP_AND_FILE | 14'h0004, 1);
    rc(A_ACCUM, 32'h0C);
    wr(A_ACCUM, 32'hC0);
    ex(OP_AND_FILE | 14'h0084, 1);
    rc(A_MEM + 8'h10, 32'h0);
    rc(A_ACCUM, 32'hC0);
    rd(A_STATUS);
    chk(rdat & 32'h4, 32'h4);
    ex(OP_AND_FILE | 14'h0080, 2);
    $display("test and file done");
  endtask
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_prog;
    t_ctl;
    t_inh;
    t_ptr;
    t_ind;
    t_andf;
    results;
  end
endmodule

// >>> tb/decode_monitor.sv
`timescale 1ns/1ps
module decode_monitor import decode_pkg::*; (
  input wire logic ref_clk, // core clock
  input wire logic rst_b, // async reset
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic busy, // instruction in flight
  input wire logic wdt_clear, // kick pulse
  input wire logic standby_req, // standby pulse
  input wire logic soft_reset_req // reset pulse
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Instruction timing
  // ----------------------------------------------------------------
  AST_BUSY_BOUND:
    assert property ($rose(busy) |-> ##[1:3] !busy)
      else $error("instruction ran past three cycles");
  AST_BUSY_FROM_WRITE:
    assert property ($rose(busy) |-> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("instruction started without accepted write");
  AST_KICK_PULSE:
    assert property (wdt_clear |=> !wdt_clear)
      else $error("kick pulse wider than one cycle");
  AST_KICK_ONE_CYCLE:
    assert property (wdt_clear |-> !busy && $past(busy) && !$past(busy, 2))
      else $error("kick did not take exactly one cycle");
  AST_STANDBY_ONE_CYCLE:
    assert property (standby_req |-> !busy && $past(busy) && !$past(busy, 2))
      else $error("standby did not take exactly one cycle");
  AST_RESET_ONE_CYCLE:
    assert property (soft_reset_req |-> !busy && $past(busy)
                     && !$past(busy, 2))
      else $error("software reset did not take one cycle");
  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=>
                     s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=>
                     s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
  cover property (busy [*3]);
  cover property ($rose(standby_req));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind control_and_indirect_op_decode decode_monitor i_decode_monitor (
  .ref_clk, .rst_b, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .busy, .wdt_clear,
  .standby_req, .soft_reset_req
);

// >>> tb/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model import decode_pkg::*; (
  input wire logic ref_clk, // fetch clock
  input wire logic [14:0] pc, // fetch address
  output logic [13:0] instr // fetched word, one clock late
);
  logic [13:0] rom [16];
  // Only four address bits decode, so higher pages alias onto the
  // sixteen-word test program; empty words read as no-operation.
  initial begin
    for (int i = 0; i < 16; i++)
      rom[i] = 14'h0000;
    rom[0] = OP_ABS_JUMP | 14'h0008;
    rom[4] = OP_REL_LIT | 14'h0002;
    rom[7] = OP_EXIT_LIT | 14'h005A;
    rom[8] = OP_INVOKE | 14'h0004;
    rom[9] = OP_AND_LIT | 14'h000F;
    rom[10] = OP_ADD_LIT | 14'h00F6;
    rom[11] = OP_KICK;
    rom[12] = OP_SW_RESET;
  end
  always_ff @(posedge ref_clk) begin
    instr <= rom[pc[3:0]];
  end
endmodule
